// ### ppr_defs.svh
/*
 Constants of the process regulator: timing, scaling, register map.
 Assumes a 25 MHz system clock and a 1 ms control tick.
*/
`ifndef PPR_DEFS_SVH
`define PPR_DEFS_SVH
// Timing in ns
`define PPR_CLK_NS 40
`define PPR_TICK_NS 1000000
`define PPR_DSEC_NS 100000000
`define PPR_CSEC_NS 10000000
// Scaling, percent in 0.01 % units
`define PPR_FULL 10000
`define PPR_ADC_SH 12
`define PPR_DPCT 10
`define PPR_PCT 100
`define PPR_GDIV 100
`define PPR_ODIV 10
// Register word indexes, byte address is index times four
`define PPR_R_MODE 5'h00
`define PPR_R_TGT 5'h01
`define PPR_R_FBG 5'h02
`define PPR_R_PG 5'h03
`define PPR_R_TI 5'h04
`define PPR_R_TD 5'h05
`define PPR_R_BIAS 5'h06
`define PPR_R_FILT 5'h07
`define PPR_R_ILIM 5'h08
`define PPR_R_OLIM 5'h09
`define PPR_R_OG 5'h0a
`define PPR_R_RAMP 5'h0b
`define PPR_R_LLVL 5'h0c
`define PPR_R_LTIM 5'h0d
`define PPR_R_SFRQ 5'h0e
`define PPR_R_SDLY 5'h0f
`define PPR_R_WFRQ 5'h10
`define PPR_R_WDLY 5'h11
`define PPR_R_FMAX 5'h12
`define PPR_R_STAT 5'h13
`define PPR_R_FREQ 5'h14
`define PPR_NCFG 19
// Mode register fields
`define PPR_M_EN 0
`define PPR_M_NEG 1
`define PPR_M_DFB 2
`define PPR_M_ADD 3
`define PPR_M_REV 4
`define PPR_M_LOSS 6:5
`define PPR_M_SLP 8:7
`define PPR_M_TSRC 11:9
`define PPR_M_FSRC 13:12
// Codes
`define PPR_SRC_A1 3'h1
`define PPR_SRC_A2 3'h2
`define PPR_SRC_REG 3'h4
`define PPR_LOSS_WARN 2'h1
`define PPR_LOSS_FLT 2'h2
`define PPR_SLP_EN 2'h1
`define PPR_SLP_DI 2'h2
`define PPR_ST_FLT 1
// Reset values
`define PPR_RV_MODE 16'h2200
`define PPR_RV_GAIN 16'h0064
`define PPR_RV_LIM 16'h03e8
`define PPR_RV_OG 16'h000a
`define PPR_RV_FMAX 16'h1770
`endif

// ### ppr_drive_model.sv
/*
 Far side of the regulator: process sensor on analog input one and drive speed path.
 Assumes the bench sets the sensed level; speed follows the reference only while allowed to run.
*/
`timescale 1ns/1ps
module ppr_drive_model
    import ppr_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic [11:0]        fbLevel,
    input  wire ppr_pkg::pprDrvOut_t drvOut,
    output logic [11:0]             analogInputOne,
    output logic [15:0]             outFreq
);
    // Sensor sample lags the process by one clock
    always_ff @(posedge clk_sys) begin
        analogInputOne <= rst ? 12'h000 : fbLevel;
    end
    // Motor slews up toward the reference, drops to a lower reference at once, coasts down when stopped
    always_ff @(posedge clk_sys) begin
        if (rst || !drvOut.runCmd) begin
            outFreq <= (outFreq > 16'h000a && !rst) ? outFreq - 16'h000a : 16'h0000;
        end else if (outFreq + 16'h000a < drvOut.freqRef) begin
            outFreq <= outFreq + 16'h000a;
        end else begin
            outFreq <= drvOut.freqRef;
        end
    end
endmodule

// ### ppr_pkg.sv
/*
 Types of the process regulator: bus and drive carriers, sleep states.
 Assumes ppr_defs.svh supplies the numeric constants.
*/
package ppr_pkg;
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } pprAhbReq_t;
    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } pprAhbRsp_t;
    typedef struct packed {
        logic [11:0] analogInputOne;
        logic [11:0] analogInputTwo;
        logic [15:0] outFreq;
        logic        diRampBypass;
        logic        diSleepEn;
    } pprDrvIn_t;
    typedef struct packed {
        logic [15:0] freqRef;
        logic        reverseDir;
        logic        runCmd;
        logic        asleep;
        logic        lossWarn;
        logic        lossFault;
        logic        faultContact;
        logic        sourceConflictAlarm;
    } pprDrvOut_t;
    typedef enum logic [1:0] {ST_RUN = 2'b01, ST_SLEEP = 2'b10} pprSlp_t;
endpackage

// ### ppr_regulator.sv
/*
 Process regulator with target ramp, feedback-loss watch and sleep/wake.
 Assumes an AHB-Lite master with single word transfers, synchronous drive inputs.
*/
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "ppr_defs.svh"
module ppr_regulator #(
    parameter int TICK_CYC = `PPR_TICK_NS / `PPR_CLK_NS
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire ppr_pkg::pprAhbReq_t ahbReq,
    output      ppr_pkg::pprAhbRsp_t ahbRsp,
    input  wire ppr_pkg::pprDrvIn_t  drvIn,
    output      ppr_pkg::pprDrvOut_t drvOut
);
    import ppr_pkg::*;

    localparam int TK_DS = `PPR_DSEC_NS / `PPR_TICK_NS;
    localparam int TK_CS = `PPR_CSEC_NS / `PPR_TICK_NS;
    localparam int RU = TICK_CYC * TK_DS / `PPR_FULL;
    localparam int RAMP_UNIT = (RU < 1) ? 1 : RU;

    typedef logic signed [47:0] pprS_t;

    logic [15:0] cfgR [0:`PPR_NCFG-1];
    logic        wrPend_r;
    logic [4:0]  wrIdx_r;
    logic [31:0] hrdata_r;
    logic [31:0] tickCnt_r;
    logic        tick_r;
    logic [31:0] rampCnt_r;
    pprS_t       tgtRamp_r, iSum_r, dPrev_r, filt_r;
    logic [15:0] freq_r;
    logic        rev_r, warn_r, fault_r, conf_r, run_r;
    logic [19:0] lossCnt_r, slpCnt_r, wakeCnt_r;
    pprSlp_t     state_r;

    logic [15:0] mode;
    logic        modeEn, conflict, fbLow, lossDet, slpEn, clrFlt;
    logic [2:0]  tSel;
    pprS_t       tgtRaw, fbS, err, pT, iT, dT, dSrc, sum, lim;
    pprS_t       iBnd, iNxt, fNxt, comp, mag, fq;
    logic [19:0] lossLim, slpLim, wakeLim;
    logic [15:0] freqNxt;
    logic        revNxt;

    function automatic pprS_t s48(input logic [15:0] v);
        return $signed({32'h0, v});
    endfunction

    function automatic pprS_t ain(input logic [11:0] v);
        return ($signed({36'h0, v}) * `PPR_FULL) >>> `PPR_ADC_SH;
    endfunction

    function automatic pprS_t clampS(input pprS_t v, input pprS_t b);
        return (v > b) ? b : ((v < -b) ? -b : v);
    endfunction

    // Bus response: hrdata straight from a flop, hreadyout tied high, hresp tied low
    assign ahbRsp = '{hreadyout: 1'b1, hresp: 1'b0, hrdata: hrdata_r};

    // Drive outputs straight from flops, except asleep, decoded from state_r
    assign drvOut = '{freqRef: freq_r, reverseDir: rev_r, runCmd: run_r,
                      asleep: state_r == ST_SLEEP, lossWarn: warn_r,
                      lossFault: fault_r, faultContact: fault_r,
                      sourceConflictAlarm: conf_r};

    // Address phase capture and read data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrPend_r <= 1'b0;
            wrIdx_r  <= 5'h00;
            hrdata_r <= 32'h0000_0000;
        end else begin
            wrPend_r <= 1'b0;
            if (ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready) begin
                wrPend_r <= ahbReq.hwrite;
                wrIdx_r  <= ahbReq.haddr[6:2];
                hrdata_r <= 32'h0000_0000;
                if (!ahbReq.hwrite) begin
                    if (ahbReq.haddr[7]) begin
                        hrdata_r <= 32'h0000_0000;
                    end else if (ahbReq.haddr[6:2] < 5'(`PPR_NCFG)) begin
                        hrdata_r <= {16'h0000, cfgR[ahbReq.haddr[6:2]]};
                    end else if (ahbReq.haddr[6:2] == `PPR_R_STAT) begin
                        hrdata_r <= {25'h0, modeEn, conf_r, rev_r,
                                     state_r == ST_SLEEP, warn_r, fault_r, run_r};
                    end else if (ahbReq.haddr[6:2] == `PPR_R_FREQ) begin
                        hrdata_r <= {16'h0000, freq_r};
                    end
                end
            end
        end
    end

    // Configuration words, written in the data phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < `PPR_NCFG; i++) begin
                cfgR[i] <= 16'h0000;
            end
            cfgR[`PPR_R_MODE] <= `PPR_RV_MODE;
            cfgR[`PPR_R_FBG]  <= `PPR_RV_GAIN;
            cfgR[`PPR_R_PG]   <= `PPR_RV_GAIN;
            cfgR[`PPR_R_ILIM] <= `PPR_RV_LIM;
            cfgR[`PPR_R_OLIM] <= `PPR_RV_LIM;
            cfgR[`PPR_R_OG]   <= `PPR_RV_OG;
            cfgR[`PPR_R_FMAX] <= `PPR_RV_FMAX;
        end else if (wrPend_r && wrIdx_r < 5'(`PPR_NCFG)) begin
            cfgR[wrIdx_r] <= ahbReq.hwdata[15:0];
        end
    end

    assign clrFlt = wrPend_r && wrIdx_r == `PPR_R_STAT && ahbReq.hwdata[`PPR_ST_FLT];

    // Control tick generator
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tickCnt_r <= 32'h0;
            tick_r    <= 1'b0;
        end else begin
            tick_r    <= tickCnt_r == 32'(TICK_CYC - 1);
            tickCnt_r <= (tickCnt_r == 32'(TICK_CYC - 1)) ? 32'h0 : tickCnt_r + 32'h1;
        end
    end

    // Source selection, scaling and correction terms
    always_comb begin
        mode     = cfgR[`PPR_R_MODE];
        modeEn   = mode[`PPR_M_EN];
        tSel     = mode[`PPR_M_TSRC];
        conflict = tSel == {1'b0, mode[`PPR_M_FSRC]};
        case (tSel)
            `PPR_SRC_A1:  tgtRaw = ain(drvIn.analogInputOne);
            `PPR_SRC_A2:  tgtRaw = ain(drvIn.analogInputTwo);
            `PPR_SRC_REG: tgtRaw = s48(cfgR[`PPR_R_TGT]) * `PPR_DPCT;
            default:      tgtRaw = '0;
        endcase
        case (mode[`PPR_M_FSRC])
            2'h1:    fbS = ain(drvIn.analogInputOne);
            2'h2:    fbS = ain(drvIn.analogInputTwo);
            default: fbS = '0;
        endcase
        fbS  = fbS * s48(cfgR[`PPR_R_FBG]) / `PPR_GDIV;
        err  = tgtRamp_r - fbS;
        pT   = err * s48(cfgR[`PPR_R_PG]) / `PPR_GDIV;
        iBnd = s48(cfgR[`PPR_R_ILIM]) * `PPR_DPCT * s48(cfgR[`PPR_R_TI]) * TK_DS;
        iNxt = clampS(iSum_r + err, iBnd);
        if (cfgR[`PPR_R_TI] == 16'h0) begin
            iT = '0;
        end else begin
            iT = iSum_r / (s48(cfgR[`PPR_R_TI]) * TK_DS);
        end
        dSrc = mode[`PPR_M_DFB] ? -fbS : err;
        dT   = (dSrc - dPrev_r) * s48(cfgR[`PPR_R_TD]) * TK_CS;
        sum  = pT + iT + dT;
        if (mode[`PPR_M_NEG]) begin
            sum = -sum;
        end
        if (mode[`PPR_M_ADD]) begin
            sum = sum + tgtRamp_r;
        end
        lim = clampS(sum, s48(cfgR[`PPR_R_OLIM]) * `PPR_DPCT);
        if (cfgR[`PPR_R_FILT] == 16'h0) begin
            fNxt = lim;
        end else begin
            fNxt = filt_r + (lim - filt_r) / (s48(cfgR[`PPR_R_FILT]) * TK_CS);
        end
        comp = filt_r * s48(cfgR[`PPR_R_OG]) / `PPR_ODIV
             + $signed({{40{cfgR[`PPR_R_BIAS][7]}}, cfgR[`PPR_R_BIAS][7:0]}) * `PPR_PCT;
        revNxt = 1'b0;
        mag    = comp;
        if (comp < 0) begin
            revNxt = mode[`PPR_M_REV];
            mag    = mode[`PPR_M_REV] ? -comp : '0;
        end
        fq = mag * s48(cfgR[`PPR_R_FMAX]) / `PPR_FULL;
        if (fq > s48(cfgR[`PPR_R_FMAX])) begin
            fq = s48(cfgR[`PPR_R_FMAX]);
        end
        freqNxt = fq[15:0];
    end

    // Target soft ramp, one unit per ramp step
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tgtRamp_r <= '0;
            rampCnt_r <= 32'h0;
        end else if (drvIn.diRampBypass || cfgR[`PPR_R_RAMP] == 16'h0) begin
            tgtRamp_r <= tgtRaw;
            rampCnt_r <= 32'h0;
        end else if (rampCnt_r + 32'h1 >= {16'h0, cfgR[`PPR_R_RAMP]} * 32'(RAMP_UNIT)) begin
            rampCnt_r <= 32'h0;
            if (tgtRamp_r < tgtRaw) begin
                tgtRamp_r <= tgtRamp_r + 48'sd1;
            end else if (tgtRamp_r > tgtRaw) begin
                tgtRamp_r <= tgtRamp_r - 48'sd1;
            end
        end else begin
            rampCnt_r <= rampCnt_r + 32'h1;
        end
    end

    // Regulator state, updated once per tick, also while asleep
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            iSum_r  <= '0;
            dPrev_r <= '0;
            filt_r  <= '0;
            freq_r  <= 16'h0;
            rev_r   <= 1'b0;
            conf_r  <= 1'b0;
        end else if (tick_r) begin
            conf_r <= conflict;
            if (!modeEn || conflict) begin
                iSum_r  <= '0;
                dPrev_r <= '0;
                filt_r  <= '0;
                freq_r  <= 16'h0;
                rev_r   <= 1'b0;
            end else begin
                iSum_r  <= (cfgR[`PPR_R_TI] == 16'h0) ? '0 : iNxt;
                dPrev_r <= dSrc;
                filt_r  <= fNxt;
                freq_r  <= freqNxt;
                rev_r   <= revNxt;
            end
        end
    end

    // Feedback loss watch
    always_comb begin
        fbLow   = fbS < s48(cfgR[`PPR_R_LLVL]) * `PPR_PCT;
        lossLim = 20'(cfgR[`PPR_R_LTIM]) * 20'(TK_DS);
        lossDet = fbLow && lossCnt_r >= lossLim;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lossCnt_r <= 20'h0;
            warn_r    <= 1'b0;
            fault_r   <= 1'b0;
        end else begin
            if (tick_r) begin
                if (!fbLow || !modeEn || mode[`PPR_M_LOSS] == 2'h0) begin
                    lossCnt_r <= 20'h0;
                end else if (lossCnt_r < lossLim) begin
                    lossCnt_r <= lossCnt_r + 20'h1;
                end
            end
            warn_r <= modeEn && lossDet && mode[`PPR_M_LOSS] == `PPR_LOSS_WARN;
            if (modeEn && lossDet && mode[`PPR_M_LOSS] == `PPR_LOSS_FLT) begin
                fault_r <= 1'b1;
            end else if (clrFlt) begin
                fault_r <= 1'b0;
            end
        end
    end

    // Sleep and wake-up sequencing
    always_comb begin
        case (mode[`PPR_M_SLP])
            `PPR_SLP_EN: slpEn = 1'b1;
            `PPR_SLP_DI: slpEn = drvIn.diSleepEn;
            default:     slpEn = 1'b0;
        endcase
        slpLim  = 20'(cfgR[`PPR_R_SDLY]) * 20'(TK_DS);
        wakeLim = 20'(cfgR[`PPR_R_WDLY]) * 20'(TK_DS);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r   <= ST_RUN;
            slpCnt_r  <= 20'h0;
            wakeCnt_r <= 20'h0;
            run_r     <= 1'b0;
        end else begin
            run_r <= state_r == ST_RUN && !fault_r && !clrFlt;
            case (state_r)
                ST_RUN: begin
                    wakeCnt_r <= 20'h0;
                    if (!slpEn || drvIn.outFreq >= cfgR[`PPR_R_SFRQ]) begin
                        slpCnt_r <= 20'h0;
                    end else if (slpCnt_r >= slpLim) begin
                        state_r  <= ST_SLEEP;
                        slpCnt_r <= 20'h0;
                    end else if (tick_r) begin
                        slpCnt_r <= slpCnt_r + 20'h1;
                    end
                end
                ST_SLEEP: begin
                    slpCnt_r <= 20'h0;
                    if (!slpEn) begin
                        state_r <= ST_RUN;
                    end else if (freq_r <= cfgR[`PPR_R_WFRQ]) begin
                        wakeCnt_r <= 20'h0;
                    end else if (wakeCnt_r >= wakeLim) begin
                        state_r   <= ST_RUN;
                        wakeCnt_r <= 20'h0;
                    end else if (tick_r) begin
                        wakeCnt_r <= wakeCnt_r + 20'h1;
                    end
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    // Checks
    a_disable_zero:
        assert property (@(posedge clk_sys) disable iff (rst)
            tick_r && !modeEn |=> freq_r == 16'h0 && !rev_r)
        else $error("frequency not zero while regulator off");

    a_integ_bound:
        assert property (@(posedge clk_sys) disable iff (rst)
            tick_r && modeEn && !conflict |=> iSum_r <= $past(iBnd) && iSum_r >= -$past(iBnd))
        else $error("integral sum past its limit");

    a_limit_out:
        assert property (@(posedge clk_sys) disable iff (rst)
            tick_r && modeEn && !conflict && cfgR[`PPR_R_FILT] == 16'h0
            |=> filt_r <= s48($past(cfgR[`PPR_R_OLIM])) * `PPR_DPCT
                && filt_r >= -(s48($past(cfgR[`PPR_R_OLIM])) * `PPR_DPCT))
        else $error("limited output outside limit");

    a_no_reverse:
        assert property (@(posedge clk_sys) disable iff (rst)
            tick_r && modeEn && !conflict && comp < 0 && !mode[`PPR_M_REV] |=> freq_r == 16'h0 && !rev_r)
        else $error("negative output not held at zero");

    a_ramp_bypass:
        assert property (@(posedge clk_sys) disable iff (rst)
            drvIn.diRampBypass |=> tgtRamp_r == $past(tgtRaw))
        else $error("bypassed target not applied");

    a_loss_warn:
        assert property (@(posedge clk_sys) disable iff (rst)
            modeEn && lossDet && mode[`PPR_M_LOSS] == `PPR_LOSS_WARN && !fault_r |=> warn_r && !fault_r)
        else $error("warning not raised on loss");

    a_fault_stop:
        assert property (@(posedge clk_sys) disable iff (rst)
            modeEn && lossDet && mode[`PPR_M_LOSS] == `PPR_LOSS_FLT |=> fault_r ##1 !run_r)
        else $error("fault did not stop drive");

    a_loss_clear:
        assert property (@(posedge clk_sys) disable iff (rst)
            tick_r && !fbLow |=> lossCnt_r == 20'h0)
        else $error("loss timer not cleared");

    a_sleep_enter:
        assert property (@(posedge clk_sys) disable iff (rst)
            state_r == ST_RUN && slpEn && drvIn.outFreq < cfgR[`PPR_R_SFRQ] && slpCnt_r >= slpLim
            |=> state_r == ST_SLEEP ##1 !run_r)
        else $error("sleep not entered at delay");

    a_wake_exit:
        assert property (@(posedge clk_sys) disable iff (rst)
            state_r == ST_SLEEP && slpEn && freq_r > cfgR[`PPR_R_WFRQ] && wakeCnt_r >= wakeLim
            |=> state_r == ST_RUN)
        else $error("wake-up not taken at delay");

    a_conflict_flag:
        assert property (@(posedge clk_sys) disable iff (rst)
            tick_r && conflict |=> conf_r && freq_r == 16'h0)
        else $error("source conflict not flagged");
endmodule

// ### test_process_pid_regulator_sleep.sv
/*
 Self-checking bench of the process regulator: bus access, polarity, loss watch, sleep.
 Assumes a short control tick of 100 clocks and a single AHB-Lite slave with hready looped back.
*/
`timescale 1ns/1ps
module test_process_pid_regulator_sleep;
    import ppr_pkg::*;
    localparam int TK = 100;
    logic        clk_sys, rst;
    pprAhbReq_t  bus, ahbReq;
    pprAhbRsp_t  ahbRsp;
    pprDrvIn_t   drvIn;
    pprDrvOut_t  drvOut;
    logic [11:0] fbLevel, ain1;
    logic [15:0] outFreq;
    logic        bypass, slpEn;
    logic [31:0] rd;
    int          n_fail, num_checks;
    // Bus and drive inputs assembled around the partner outputs
    assign ahbReq = {bus[71:1], ahbRsp.hreadyout};
    assign drvIn  = {ain1, 12'h000, outFreq, bypass, slpEn};
    ppr_regulator #(.TICK_CYC(TK)) i_ppr_regulator (.clk_sys(clk_sys), .rst(rst), .ahbReq(ahbReq),
        .ahbRsp(ahbRsp), .drvIn(drvIn), .drvOut(drvOut));
    ppr_drive_model i_ppr_drive_model (.clk_sys(clk_sys), .rst(rst), .fbLevel(fbLevel), .drvOut(drvOut),
        .analogInputOne(ain1), .outFreq(outFreq));
    // 25 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One single-word transfer; waits on hready in both phases
    task automatic xfer(input logic wr, input logic [4:0] idx, input logic [31:0] wd);
        bus.hsel <= 1'b1;
        bus.haddr <= {25'h0, idx, 2'b00};
        bus.htrans <= 2'h2;
        bus.hwrite <= wr;
        bus.hsize <= 3'h2;
        do begin @(posedge clk_sys); end while (ahbRsp.hreadyout !== 1'b1);
        bus.htrans <= 2'h0;
        bus.hsel <= 1'b0;
        bus.hwdata <= wd;
        do begin @(posedge clk_sys); end while (ahbRsp.hreadyout !== 1'b1);
        rd = ahbRsp.hrdata;
    endtask
    task automatic ticks(input int k);
        repeat (k * TK) @(posedge clk_sys);
    endtask
    task automatic t_regs();
        xfer(0, 5'h00, 0); chk("mode reset", 32'h00002200, rd);
        xfer(0, 5'h03, 0); chk("pgain reset", 32'h00000064, rd);
        xfer(0, 5'h0a, 0); chk("ogain reset", 32'h0000000a, rd);
        xfer(0, 5'h12, 0); chk("fmax reset", 32'h00001770, rd);
        xfer(1, 5'h04, 32'h123400ab); xfer(0, 5'h04, 0); chk("itime low half", 32'h000000ab, rd);
        xfer(1, 5'h04, 32'h0); xfer(0, 5'h15, 0); chk("unmapped", 32'h0, rd);
        chk("freqRef idle", 32'h0, drvOut.freqRef);
    endtask
    task automatic t_conflict();
        xfer(1, 5'h00, 32'h1201); ticks(3);
        chk("conflict alarm", 32'h1, drvOut.sourceConflictAlarm);
        chk("freqRef conflict", 32'h0, drvOut.freqRef);
    endtask
    task automatic t_polarity();
        xfer(1, 5'h01, 32'd500); xfer(1, 5'h00, 32'h1801); ticks(3);
        chk("freqRef forward", 32'h1, drvOut.freqRef != 16'h0);
        xfer(1, 5'h00, 32'h1803); ticks(3);
        chk("freqRef held zero", 32'h0, drvOut.freqRef);
        chk("no reversal", 32'h0, drvOut.reverseDir);
        xfer(1, 5'h00, 32'h1813); ticks(3);
        chk("reversal", 32'h1, drvOut.reverseDir);
        xfer(1, 5'h00, 32'h1800); ticks(3);
        chk("freqRef disabled", 32'h0, drvOut.freqRef);
    endtask
    // Output shaping: limits, integral, bias, target add, gain, ramp
    task automatic t_shape();
        xfer(1, 5'h09, 32'd200); xfer(1, 5'h00, 32'h1801); ticks(3);
        chk("freqRef limited", 32'd1200, drvOut.freqRef);
        xfer(1, 5'h09, 32'd1000); xfer(1, 5'h03, 32'd0); xfer(1, 5'h04, 32'd1); xfer(1, 5'h08, 32'd1); ticks(5);
        chk("integral limited", 32'd6, drvOut.freqRef);
        xfer(1, 5'h04, 32'd0); ticks(3);
        chk("integral off", 32'h0, drvOut.freqRef);
        xfer(1, 5'h06, 32'd10); ticks(3);
        chk("freqRef bias", 32'd600, drvOut.freqRef);
        xfer(1, 5'h06, 32'd0); xfer(1, 5'h00, 32'h1809); ticks(3);
        chk("freqRef plus target", 32'd3000, drvOut.freqRef);
        xfer(1, 5'h00, 32'h1801); xfer(1, 5'h03, 32'h64); xfer(1, 5'h0a, 32'd20); ticks(3);
        chk("freqRef output gain", 32'd6000, drvOut.freqRef);
        xfer(1, 5'h0a, 32'd10); xfer(1, 5'h0b, 32'd1); xfer(1, 5'h01, 32'd1000); ticks(3);
        chk("target ramping", 32'h1, drvOut.freqRef < 16'd6000);
        bypass <= 1'b1; ticks(3);
        chk("ramp bypassed", 32'd6000, drvOut.freqRef);
        bypass <= 1'b0; xfer(1, 5'h0b, 32'd0); xfer(1, 5'h01, 32'd500); xfer(1, 5'h08, 32'd1000);
        xfer(1, 5'h00, 32'h1800);
    endtask
    task automatic t_loss();
        xfer(1, 5'h0c, 32'd50); xfer(1, 5'h0d, 32'd1); xfer(1, 5'h00, 32'h1821); ticks(90);
        chk("warn early", 32'h0, drvOut.lossWarn);
        ticks(15);
        chk("warn", 32'h1, drvOut.lossWarn);
        chk("run in warn", 32'h1, drvOut.runCmd);
        fbLevel <= 12'hfff; ticks(3);
        chk("warn cleared", 32'h0, drvOut.lossWarn);
        fbLevel <= 12'h000; xfer(1, 5'h00, 32'h1841); ticks(105);
        chk("fault", 32'h3, {drvOut.lossFault, drvOut.faultContact});
        chk("run stopped", 32'h0, drvOut.runCmd);
        fbLevel <= 12'hfff; xfer(1, 5'h00, 32'h1801); xfer(1, 5'h13, 32'h2); ticks(2);
        chk("fault cleared", 32'h0, drvOut.lossFault);
        fbLevel <= 12'h000;
    endtask
    task automatic t_sleep();
        xfer(1, 5'h0e, 32'd1000); xfer(1, 5'h0f, 32'd1); xfer(1, 5'h10, 32'd500);
        xfer(1, 5'h11, 32'd1); xfer(1, 5'h00, 32'h1880); ticks(105);
        chk("asleep", 32'h1, drvOut.asleep);
        xfer(1, 5'h00, 32'h1881); ticks(3);
        chk("computing asleep", 32'h3, {drvOut.asleep, drvOut.freqRef != 16'h0});
        ticks(105);
        chk("woken", 32'h1, {drvOut.asleep, drvOut.runCmd});
        slpEn <= 1'b1; xfer(1, 5'h00, 32'h1900); ticks(110);
        chk("asleep by input", 32'h1, drvOut.asleep);
        slpEn <= 1'b0; ticks(1);
        chk("input wakes", 32'h0, drvOut.asleep);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Watchdog well past the planned run length
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_fail++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        n_fail = 0;
        num_checks = 0;
        rst = 1'b1;
        bus = '0;
        fbLevel = 12'h000;
        bypass = 1'b0;
        slpEn = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_conflict();
        t_polarity();
        t_shape();
        t_loss();
        t_sleep();
        report_and_stop();
    end
endmodule
